// ### comparator_control_defines.svh
// register offsets, field positions and reset values of the comparator control block
// Operation
// - Comparator flag sets on selected output edge; single vector at offset zero.
// - Edge select: 0 both, 2 falling, 3 rising, 1 reserved (no edges).
// - Interrupt request high while enable and flag both set, until flag cleared.
// - Interrupt enable register at 0x06, bit 0 gates the source.
// - Status at 0x07: flag bit 0, live comparator state bit 4.
// - Standby with keep-running: compare, events, pad live; status frozen without clock request.
// - Idle sleep behaves exactly as active mode.
// - Power-down disables comparator and pad output always.
// - Control bit 6 drives comparator result onto output pin.
// - While enabled, raw unsynchronised result goes to event network; no event inputs.
// - Control bit 0 enables comparing; control register resets to zero, read-write.
// - Hysteresis field at control bits 2:1: off, 10, 25, 50 mV.
// - Control bit 3 selects low bias current, slower reaction.
// - Positive input among four pins; negative among two pins, converter, reference.
// - Halted debug leaves the block running unchanged.
// - Register, flag and interrupt logic run on the peripheral clock.
// - Positive select at bits 4:3 picks positive pins zero to three.
// - Negative select bits 1:0: pins 0,1; 2 reference; 3 converter output.
// - Writing one clears the flag; state bit follows after synchroniser delay.
// - Input select bit 7 inverts result for every consumer.
`ifndef COMPARATOR_CONTROL_DEFINES_SVH
`define COMPARATOR_CONTROL_DEFINES_SVH

`define CMPC_ADDR_W 3
`define CMPC_OFS_CONTROL 3'h0
`define CMPC_OFS_INPUT_SELECT 3'h2
`define CMPC_OFS_IRQ_ENABLE 3'h6
`define CMPC_OFS_FLAGS 3'h7

`define CMPC_CTRL_ENABLE 0
`define CMPC_CTRL_HYS_LO 1
`define CMPC_CTRL_LOWPWR 3
`define CMPC_CTRL_EDGE_LO 4
`define CMPC_CTRL_PAD_OE 6
`define CMPC_CTRL_KEEP_RUN 7

`define CMPC_SEL_NEG_LO 0
`define CMPC_SEL_POS_LO 3
`define CMPC_SEL_INVERT 7
`define CMPC_SEL_MASK 8'h9b

`define CMPC_IRQEN_BIT 0
`define CMPC_FLAG_BIT 0
`define CMPC_STATE_BIT 4

`define CMPC_RESET_BYTE 8'h00

`define CMPC_EDGE_EITHER 2'h0
`define CMPC_EDGE_FALL 2'h2
`define CMPC_EDGE_RISE 2'h3

`define CMPC_VECTOR_OFS 8'h00

`define CMPC_CLK_MHZ 25
`define CMPC_STARTUP_NS 2500
`define CMPC_REF_STARTUP_NS 60000
`define CMPC_STARTUP_CYC ((`CMPC_STARTUP_NS * `CMPC_CLK_MHZ + 999) / 1000)
`define CMPC_REF_STARTUP_CYC ((`CMPC_REF_STARTUP_NS * `CMPC_CLK_MHZ + 999) / 1000)

`endif

// ### comparator_control_pkg.sv
// types shared by the comparator control block
package comparator_control_pkg;

	typedef enum logic [1:0] {
		pwr_active,
		pwr_idle,
		pwr_standby,
		pwr_power_down
	} sleep_mode_e;

	typedef struct packed {
		logic keep_running_in_standby;
		logic pad_output_enable;
		logic [1:0] irq_edge_select;
		logic low_power_select;
		logic [1:0] hysteresis_select;
		logic enable;
	} control_s;

	typedef struct packed {
		logic invert;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} input_select_s;

	// analog front-end settings handed to the comparator core
	typedef struct packed {
		logic powered;
		logic low_power_select;
		logic [1:0] hysteresis_select;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} analog_cfg_s;

endpackage : comparator_control_pkg

// ### comparator_sync3.sv
// three-stage synchroniser for the asynchronous comparator result
`timescale 1ns/1ps
module comparator_sync3 (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// asynchronous level in, settled level out
	input wire logic async_i,
	output logic level_o
);

	logic meta_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// a change counts only once the second and third stage agree
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			meta_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			meta_r <= async_i;
			s2_r <= meta_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end

	assign level_o = level_r;

endmodule : comparator_sync3

// ### comparator_edge_detect.sv
// edge detector that turns the settled comparator level into a flag-set pulse
`timescale 1ns/1ps
`include "comparator_control_defines.svh"
module comparator_edge_detect (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// level, qualifier and edge choice
	input wire logic level_i,
	input wire logic update_i,
	input wire logic [1:0] edge_select_i,
	output logic hit_o
);

	logic last_r;
	wire rise = level_i & ~last_r;
	wire fall = ~level_i & last_r;

	// last value follows only while updates are allowed, so a frozen
	// period ends with one catch-up edge instead of a lost one
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			last_r <= 1'b0;
		end else if (update_i) begin
			last_r <= level_i;
		end
	end

	assign hit_o = update_i & (
		(edge_select_i == `CMPC_EDGE_EITHER) ? (rise | fall) :
		(edge_select_i == `CMPC_EDGE_FALL) ? fall :
		(edge_select_i == `CMPC_EDGE_RISE) ? rise : 1'b0);

endmodule : comparator_edge_detect

// ### comparator_control.sv
// register file, sleep gating and flag logic around the analog comparator
`timescale 1ns/1ps
`include "comparator_control_defines.svh"
module comparator_control (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// avalon-mm slave
	input wire logic [`CMPC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [7:0] avs_writedata_i,
	output logic [7:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// power management
	input wire comparator_control_pkg::sleep_mode_e sleep_mode_i,
	input wire logic clk_request_i,
	// analog core
	input wire logic comparator_raw_i,
	output comparator_control_pkg::analog_cfg_s analog_cfg_o,
	// pad, event and interrupt
	output logic pad_out_o,
	output logic pad_oe_o,
	output logic event_out_o,
	output logic irq_o,
	output logic [7:0] irq_vector_o
);

	comparator_control_pkg::control_s ctrl_r;
	comparator_control_pkg::input_select_s sel_r;
	logic irq_en_r;
	logic flag_r;
	logic state_r;
	logic rd_done_r;
	logic [7:0] rdata_r;

	// bus decode
	wire hit_ctrl = avs_address_i == `CMPC_OFS_CONTROL;
	wire hit_sel = avs_address_i == `CMPC_OFS_INPUT_SELECT;
	wire hit_ien = avs_address_i == `CMPC_OFS_IRQ_ENABLE;
	wire hit_flags = avs_address_i == `CMPC_OFS_FLAGS;
	wire wr = avs_write_i;

	// sleep decode
	wire in_standby = sleep_mode_i == comparator_control_pkg::pwr_standby;
	wire in_pdown = sleep_mode_i == comparator_control_pkg::pwr_power_down;

	// power-down stops comparator and pad, standby needs keep-running
	wire powered = ctrl_r.enable & ~in_pdown &
		(~in_standby | ctrl_r.keep_running_in_standby);
	// no clock in standby unless requested; idle as active; debug ignored
	wire clk_live = ~in_standby | clk_request_i;
	wire update = powered & clk_live;

	// inversion before every consumer, raw asynchronous path
	wire result = (comparator_raw_i ^ sel_r.invert) & powered;

	logic settled;
	logic hit;

	// synchroniser delay on the state bit
	comparator_sync3 u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(result),
		.level_o(settled)
	);

	comparator_edge_detect u_edge (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.level_i(settled),
		.update_i(update),
		.edge_select_i(ctrl_r.irq_edge_select),
		.hit_o(hit)
	);

	// all registers on the peripheral clock
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_r <= `CMPC_RESET_BYTE;
		end else if (wr && hit_ctrl) begin
			ctrl_r <= avs_writedata_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			sel_r <= '0;
		end else if (wr && hit_sel) begin
			sel_r <= {avs_writedata_i[`CMPC_SEL_INVERT],
				avs_writedata_i[`CMPC_SEL_POS_LO+1:`CMPC_SEL_POS_LO],
				avs_writedata_i[`CMPC_SEL_NEG_LO+1:`CMPC_SEL_NEG_LO]};
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_en_r <= 1'b0;
		end else if (wr && hit_ien) begin
			irq_en_r <= avs_writedata_i[`CMPC_IRQEN_BIT];
		end
	end

	wire flag_clr = wr & hit_flags & avs_writedata_i[`CMPC_FLAG_BIT];

	// set wins over a same-cycle clear
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			flag_r <= 1'b0;
		end else if (hit) begin
			flag_r <= 1'b1;
		end else if (flag_clr) begin
			flag_r <= 1'b0;
		end
	end

	// state bit frozen while the clock is withheld
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= 1'b0;
		end else if (clk_live) begin
			state_r <= settled;
		end
	end

	// read mux, zeros for reserved bits and offsets
	wire [7:0] rd_mux =
		hit_ctrl ? ctrl_r :
		hit_sel ? {sel_r.invert, 2'b00, sel_r.positive_input_select, 1'b0,
			sel_r.negative_input_select} :
		hit_ien ? {7'h00, irq_en_r} :
		hit_flags ? {3'h0, state_r, 3'h0, flag_r} : 8'h00;

	// reads take one wait cycle so data comes from a flip-flop
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rd_done_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			rd_done_r <= avs_read_i & ~rd_done_r;
			rdata_r <= rd_mux;
		end
	end

	assign avs_waitrequest_o = avs_read_i & ~rd_done_r;
	assign avs_readdata_o = rdata_r;

	assign analog_cfg_o = {powered, ctrl_r.low_power_select, ctrl_r.hysteresis_select,
		sel_r.positive_input_select, sel_r.negative_input_select};

	assign pad_oe_o = ctrl_r.pad_output_enable & powered;
	assign pad_out_o = result;
	assign event_out_o = result;
	assign irq_o = irq_en_r & flag_r;
	assign irq_vector_o = `CMPC_VECTOR_OFS;

endmodule : comparator_control

// ### comparator_control_asserts.sv
// port-level checks of the comparator control block
`timescale 1ns/1ps
`include "comparator_control_defines.svh"
module comparator_control_asserts (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// bus
	input wire logic [`CMPC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [7:0] avs_writedata_i,
	input wire logic [7:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// power, core, pad and irq
	input wire comparator_control_pkg::sleep_mode_e sleep_mode_i,
	input wire logic clk_request_i,
	input wire logic comparator_raw_i,
	input wire comparator_control_pkg::analog_cfg_s analog_cfg_o,
	input wire logic pad_out_o,
	input wire logic pad_oe_o,
	input wire logic event_out_o,
	input wire logic irq_o,
	input wire logic [7:0] irq_vector_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	wire pd = sleep_mode_i == comparator_control_pkg::pwr_power_down;
	wire rd_ok = avs_read_i && !avs_waitrequest_o;
	property p_vec; irq_vector_o == 8'h00; endproperty
	a_vec: assert property (p_vec) else $error("vector not zero");
	property p_pd; pd |-> !analog_cfg_o.powered && !pad_oe_o; endproperty
	a_pd: assert property (p_pd) else $error("active in power-down");
	property p_ev; event_out_o == pad_out_o; endproperty
	a_ev: assert property (p_ev) else $error("event differs from pad");
	property p_off; !analog_cfg_o.powered |-> !pad_out_o; endproperty
	a_off: assert property (p_off) else $error("result while off");
	property p_oe; pad_oe_o |-> analog_cfg_o.powered; endproperty
	a_oe: assert property (p_oe) else $error("pad driven while off");
	property p_wr; avs_write_i |-> !avs_waitrequest_o; endproperty
	a_wr: assert property (p_wr) else $error("write stalled");
	property p_rd; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
	a_rd: assert property (p_rd) else $error("read wait wrong");
	property p_irq; $fell(irq_o) |-> $past(avs_write_i && avs_address_i inside {3'h6, 3'h7}); endproperty
	a_irq: assert property (p_irq) else $error("irq dropped uncleared");
	property p_rsv; rd_ok && avs_address_i inside {3'h1, [3'h3:3'h5]} |-> avs_readdata_o == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved offset not zero");
	property p_st; rd_ok && avs_address_i == 3'h7 |-> (avs_readdata_o & 8'hee) == 8'h00; endproperty
	a_st: assert property (p_st) else $error("status reserved bits set");
	c_irq: cover property ($rose(irq_o));
	c_pd: cover property (pd);
	c_rd: cover property (rd_ok);
endmodule : comparator_control_asserts
bind comparator_control comparator_control_asserts i_chk (.clk_sys_i, .reset_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
	.sleep_mode_i, .clk_request_i, .comparator_raw_i, .analog_cfg_o, .pad_out_o, .pad_oe_o,
	.event_out_o, .irq_o, .irq_vector_o);

// ### irq_sink.sv
// stand-in for interrupt controller and event network, counting arrivals
`timescale 1ns/1ps
module irq_sink (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// from the block
	input wire logic irq_i,
	input wire logic event_i,
	output logic [7:0] irq_count_o,
	output logic [7:0] event_count_o
);
	logic irq_q;
	logic [7:0] ev_r = 8'h00;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_q <= 1'b0;
			irq_count_o <= 8'h00;
		end else begin
			irq_q <= irq_i;
			irq_count_o <= irq_count_o + 8'(irq_i && !irq_q);
		end
	end
	always @(posedge event_i) ev_r <= ev_r + 8'h01;
	assign event_count_o = ev_r;
endmodule : irq_sink

// ### tb.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "comparator_control_defines.svh"
module tb;
	logic clk_sys_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0, clk_request_i = 0;
	logic comparator_raw_i = 0, avs_waitrequest_o, pad_out_o, pad_oe_o, event_out_o, irq_o, f;
	logic [`CMPC_ADDR_W-1:0] avs_address_i = 0;
	logic [7:0] avs_writedata_i = 0, avs_readdata_o, irq_vector_o, q, ni, ne, irq_count, ev_count;
	comparator_control_pkg::sleep_mode_e sleep_mode_i = comparator_control_pkg::pwr_active;
	comparator_control_pkg::analog_cfg_s analog_cfg_o;
	int bad_count = 0, samples_checked = 0;
	// write flag, offset, data, expected readback
	logic [7:0] rows [12][4] = '{'{0, 0, 0, 0}, '{0, 2, 0, 0}, '{0, 6, 0, 0}, '{0, 7, 0, 0},
		'{1, 0, 8'hff, 8'hff}, '{1, 2, 8'hff, 8'h9b}, '{1, 6, 8'hff, 8'h01}, '{1, 1, 8'hff, 0},
		'{1, 3, 8'hff, 0}, '{1, 5, 8'hff, 0}, '{1, 0, 0, 0}, '{1, 2, 0, 0}};
	comparator_control i_dut (.clk_sys_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_mode_i, .clk_request_i,
		.comparator_raw_i, .analog_cfg_o, .pad_out_o, .pad_oe_o, .event_out_o, .irq_o,
		.irq_vector_o);
	irq_sink i_sink (.clk_sys_i, .reset_i, .irq_i(irq_o), .event_i(event_out_o),
		.irq_count_o(irq_count), .event_count_o(ev_count));
	initial forever #20 clk_sys_i = ~clk_sys_i;
	task chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// starts just after a rising edge; held until waitrequest is seen low at an edge
	task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge clk_sys_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
		q = avs_readdata_o;
		avs_write_i <= 0;
		avs_read_i <= 0;
		@(posedge clk_sys_i);
	endtask : acc
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 0;
		@(posedge clk_sys_i);
		foreach (rows[i]) begin
			if (rows[i][0][0]) acc(1, rows[i][1][2:0], rows[i][2]);
			acc(0, rows[i][1][2:0], 0);
			chk(q, rows[i][3]);
		end
		// inputs selected before the enable write
		acc(1, 2, 8'h1a);
		acc(1, 0, 8'h0d);
		chk(analog_cfg_o, 8'hee);
		// reference start-up before the output is trusted
		repeat (`CMPC_REF_STARTUP_CYC) @(posedge clk_sys_i);
		acc(1, 2, 0);
		acc(1, 6, 8'h01);
		ni = irq_count;
		ne = ev_count;
		for (int m = 0; m < 4; m++) begin
			acc(1, 0, 8'h41 | 8'(m << 4));
			for (int r = 1; r >= 0; r--) begin
				acc(1, 7, 8'h01);
				comparator_raw_i <= r[0];
				repeat (8) @(posedge clk_sys_i);
				f = (m == 0) || (m == 2 + r);
				acc(0, 7, 0);
				chk(q, {3'h0, r[0], 3'h0, f});
				chk(irq_o, f);
				chk({pad_oe_o, pad_out_o, event_out_o}, {1'b1, r[0], r[0]});
			end
		end
		chk(irq_count - ni, 8'h04);
		chk(ev_count - ne, 8'h04);
		acc(1, 2, 8'h80);
		for (int k = 0; k < 2; k++) begin
			acc(1, 0, k ? 8'hc1 : 8'h41);
			for (int s = 0; s < 4; s++) begin
				sleep_mode_i <= comparator_control_pkg::sleep_mode_e'(s);
				@(negedge clk_sys_i);
				chk({pad_oe_o, pad_out_o}, {2{s < 2 || (k && s == 2)}});
				@(posedge clk_sys_i);
			end
		end
		// settle state high in active mode, then freeze it in standby
		sleep_mode_i <= comparator_control_pkg::pwr_active;
		repeat (8) @(posedge clk_sys_i);
		acc(1, 7, 8'h01);
		sleep_mode_i <= comparator_control_pkg::pwr_standby;
		comparator_raw_i <= 1;
		repeat (8) @(posedge clk_sys_i);
		acc(0, 7, 0);
		chk({q, pad_out_o}, {8'h10, 1'b0});
		clk_request_i <= 1;
		repeat (8) @(posedge clk_sys_i);
		acc(0, 7, 0);
		chk(q, 8'h01);
		reset_i <= 1;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 0;
		@(posedge clk_sys_i);
		acc(0, 0, 0);
		chk({q, pad_oe_o, irq_o}, 0);
		finish_test();
	end
endmodule : tb
